// >>> logic/ita_abort_src.sv
// Transmit-abort cause register with its APB slave and bus-loss check.
// Assumes the transfer engines supply outcome pulses on pclk and that
// the bus pins arrive asynchronously.
//
// What this block does
// - Read-command write while serving a remote read sets bit 15.
// - Slave losing the bus sets bit 14 together with bit 12.
// - Slave compares line with intended bit at each clock rise.
// - Read command received with data in TX FIFO sets bit 13.
// - Bit 12 flags lost arbitration, of slave when bit 14 set.
// - Master and slave causes are collected side by side.
// - Master request with master mode off sets bit 11.
// - No restart plus 10-bit read command sets bit 10.
// - No restart plus START byte attempt sets bit 9.
// - Bit 9 cleared with cause present returns after one cycle.
// - No restart plus high-speed master request sets bit 8.
// - Acknowledged START byte sets bit 7.
// - Acknowledged high-speed master code sets bit 6.
// - General call followed by queued read sets bit 5.
// - Unacknowledged general call sets bit 4.
// - Master data byte unacknowledged sets bit 3.
// - Unacknowledged second 10-bit address byte sets bit 2.
// - Unacknowledged first 10-bit address byte sets bit 1.
// - Unacknowledged 7-bit address sets bit 0.
`default_nettype none
`include "ita_params.svh"
module ita_abort_src import ita_pkg::*; #(
  parameter int AW = 32
) (
  input wire logic pclk, // System clock, 100 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [AW-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic scl_in, // Clock line level
  input wire logic sda_in, // Data line level
  input wire ita_mst_evt_t mst_evt, // Master outcome pulses
  input wire ita_slv_t slv, // Slave engine status
  output logic master_start, // Accepted master request pulse
  output logic transmit_abort_interrupt, // Any cause pending
  output logic flush_tx, // Flush TX FIFO while aborted
  output logic stop_xfer, // Halt current transfer
  output logic [15:0] abort_cause // Cause bits for the engines
);
  // Address decode compares full 32-bit words only
  if (AW != 32) begin : g_aw_chk
    $error("ita_abort_src: AW must be 32");
  end

  ita_state_t st_q, st_d;
  logic scl_s;
  logic sda_s;
  logic slv_loss;
  logic setup;
  logic access;
  logic wr;
  logic dcmd_wr;
  logic clr;
  logic attempt;
  logic mst_ok;
  logic sbyte_cause;
  logic mapped;
  logic [15:0] set_c;
  logic [31:0] rd_mux;

  // ==========================================
  // Pin synchronisers and slave ownership check
  ita_sync #(.W(2)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({scl_in, sda_in}),
    .dout({scl_s, sda_s})
  );

  ita_loss_chk u_chk (
    .pclk(pclk),
    .presetn(presetn),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .tx_active(slv.tx_active),
    .tx_bit(slv.tx_bit),
    .loss(slv_loss)
  );

  // ==========================================
  // APB phase decode; zero wait states, data latched in setup
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign pready = access;
  assign pslverr = access && st_q.err;
  assign prdata = st_q.prdata;
  assign wr = access && pwrite && !st_q.err;
  assign dcmd_wr = wr && (paddr == `ITA_ADDR_DCMD);
  // Clearing on read keeps the cause bits read-only
  assign clr = access && !pwrite && (paddr == `ITA_ADDR_CLR);

  // Address map; the clear register reads as zero
  always_comb begin
    mapped = 1'b1;
    rd_mux = `ITA_WORD_RST;
    unique case (paddr)
      `ITA_ADDR_CTRL: begin
        rd_mux[`ITA_CTRL_MST_EN] = st_q.master_en;
        rd_mux[`ITA_CTRL_HS] = st_q.hs_mode;
        rd_mux[`ITA_CTRL_RESTART] = st_q.restart_en;
      end
      `ITA_ADDR_TGT: begin
        rd_mux[`ITA_TGT_GC_START] = st_q.general_call_or_start_byte_select_sel;
        rd_mux[`ITA_TGT_COMMAND_SELECT_A] = st_q.command_select_a;
        rd_mux[`ITA_TGT_TENBIT] = st_q.ten_bit;
      end
      `ITA_ADDR_CAUSE: begin
        rd_mux[15:0] = st_q.cause;
      end
      `ITA_ADDR_DCMD, `ITA_ADDR_CLR: begin
        rd_mux = `ITA_WORD_RST;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // ==========================================
  // Request qualification from data/command writes
  // A write while serving a remote read is slave data, not a request
  assign attempt = dcmd_wr && !slv.serving_read;
  assign mst_ok = attempt && st_q.master_en;
  // START byte selected while restart is off
  assign sbyte_cause = !st_q.restart_en && st_q.command_select_a && st_q.general_call_or_start_byte_select_sel;

  // ==========================================
  // Cause set terms; master and slave sides OR in independently
  always_comb begin
    set_c = `ITA_CAUSE_RST;
    set_c[`ITA_B_SLV_RD] = dcmd_wr && pwdata[`ITA_DCMD_CMD]
      && slv.serving_read;
    set_c[`ITA_B_SLV_LOSS] = slv_loss;
    set_c[`ITA_B_SLV_FLUSH] = slv.read_cmd_rx && slv.tx_fifo_nonempty;
    set_c[`ITA_B_ARB] = mst_evt.arbitration_loss || slv_loss;
    set_c[`ITA_B_MST_DIS] = attempt && !st_q.master_en;
    set_c[`ITA_B_10B_RD] = mst_ok && !st_q.restart_en && st_q.ten_bit
      && pwdata[`ITA_DCMD_CMD];
    // Re-arm pulse brings bit 9 back a cycle after a premature clear
    set_c[`ITA_B_SB_NORS] = (mst_ok && sbyte_cause) || st_q.reassert;
    set_c[`ITA_B_HS_NORS] = mst_ok && !st_q.restart_en && st_q.hs_mode;
    set_c[`ITA_B_SB_ACK] = mst_evt.start_byte_acked;
    set_c[`ITA_B_HS_ACK] = mst_evt.hs_master_code_acked && st_q.hs_mode;
    set_c[`ITA_B_GC_READ] = mst_ok && st_q.command_select_a && !st_q.general_call_or_start_byte_select_sel
      && pwdata[`ITA_DCMD_GC_READ];
    set_c[`ITA_B_GC_NACK] = mst_evt.general_call_unacked;
    // Master only: slave-side data nacks are normal end of read
    set_c[`ITA_B_DATA] = mst_evt.data_byte_unacked && st_q.master_en;
    set_c[`ITA_B_ADDR10_2] = mst_evt.ten_bit_second_addr_unacked
      && st_q.ten_bit;
    set_c[`ITA_B_ADDR10_1] = mst_evt.ten_bit_first_addr_unacked
      && st_q.ten_bit;
    set_c[`ITA_B_ADDR7] = mst_evt.seven_bit_addr_unacked && !st_q.ten_bit;
  end

  // ==========================================
  // Next state: registers, causes and read data
  always_comb begin
    st_d = st_q;
    if (setup) begin
      st_d.prdata = rd_mux;
      st_d.err = !mapped;
    end
    if (wr && paddr == `ITA_ADDR_CTRL) begin
      st_d.master_en = pwdata[`ITA_CTRL_MST_EN];
      st_d.hs_mode = pwdata[`ITA_CTRL_HS];
      st_d.restart_en = pwdata[`ITA_CTRL_RESTART];
    end
    if (wr && paddr == `ITA_ADDR_TGT) begin
      st_d.general_call_or_start_byte_select_sel = pwdata[`ITA_TGT_GC_START];
      st_d.command_select_a = pwdata[`ITA_TGT_COMMAND_SELECT_A];
      st_d.ten_bit = pwdata[`ITA_TGT_TENBIT];
    end
    // A set in the clearing cycle survives the clear
    st_d.cause = set_c | (st_q.cause & ~{16{clr}});
    // Clear with the START-byte cause still present: drop, then return
    st_d.reassert = clr && sbyte_cause && st_q.cause[`ITA_B_SB_NORS];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================
  // Outputs; abort holds off transfers until software clears it
  assign abort_cause = st_q.cause;
  assign transmit_abort_interrupt = |st_q.cause;
  assign flush_tx = |st_q.cause;
  assign stop_xfer = |st_q.cause;
  assign master_start = mst_ok && (set_c == `ITA_CAUSE_RST) && !stop_xfer;

  // ==========================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_slv_rd_misuse: assert property (
    (dcmd_wr && pwdata[`ITA_DCMD_CMD] && slv.serving_read)
    |=> abort_cause[`ITA_B_SLV_RD])
    else $error("bit 15 missing after read-command write");

  a_slv_loss_pair: assert property (
    $rose(abort_cause[`ITA_B_SLV_LOSS]) |-> abort_cause[`ITA_B_ARB])
    else $error("bit 14 set without bit 12");

  a_slv_flush_irq: assert property (
    (slv.read_cmd_rx && slv.tx_fifo_nonempty)
    |=> abort_cause[`ITA_B_SLV_FLUSH] && transmit_abort_interrupt && flush_tx)
    else $error("stale TX flush abort not raised");

  a_master_off: assert property (
    (attempt && !st_q.master_en) |=> abort_cause[`ITA_B_MST_DIS] && !$past(master_start))
    else $error("disabled master request not aborted");

  a_ten_bit_read: assert property (
    (mst_ok && !st_q.restart_en && st_q.ten_bit && pwdata[`ITA_DCMD_CMD])
    |=> abort_cause[`ITA_B_10B_RD])
    else $error("10-bit read without restart not flagged");

  a_sbyte_rearm: assert property (
    (clr && sbyte_cause && abort_cause[`ITA_B_SB_NORS] && !mst_ok)
    |=> !abort_cause[`ITA_B_SB_NORS] ##1 abort_cause[`ITA_B_SB_NORS])
    else $error("bit 9 did not return one cycle after clear");

  a_hs_no_restart: assert property (
    (mst_ok && !st_q.restart_en && st_q.hs_mode) |=> abort_cause[`ITA_B_HS_NORS])
    else $error("high-speed without restart not flagged");

  a_gc_read: assert property (
    (mst_ok && st_q.command_select_a && !st_q.general_call_or_start_byte_select_sel && pwdata[`ITA_DCMD_GC_READ])
    |=> abort_cause[`ITA_B_GC_READ])
    else $error("general call read not flagged");

  a_addr7_nack: assert property (
    (mst_evt.seven_bit_addr_unacked && !st_q.ten_bit) |=> abort_cause[`ITA_B_ADDR7])
    else $error("7-bit address nack not flagged");

  a_clear_all: assert property (
    (clr && set_c == `ITA_CAUSE_RST) |=> abort_cause == `ITA_CAUSE_RST)
    else $error("causes not cleared by clear read");

  a_abort_holds: assert property (
    (flush_tx && !clr) |=> flush_tx && stop_xfer)
    else $error("flush dropped before clear");

  // ==========================================
  // Checks on the remaining causes and their refusals
  a_arb_with_loss: assert property (
    slv_loss |=> abort_cause[`ITA_B_SLV_LOSS] && abort_cause[`ITA_B_ARB])
    else $error("slave loss did not set bits 14 and 12");

  a_arb_master: assert property (
    mst_evt.arbitration_loss |=> abort_cause[`ITA_B_ARB])
    else $error("master arbitration loss not flagged");

  a_both_roles: assert property (
    (slv.read_cmd_rx && slv.tx_fifo_nonempty && mst_evt.seven_bit_addr_unacked
      && !st_q.ten_bit) |=> abort_cause[`ITA_B_SLV_FLUSH] && abort_cause[`ITA_B_ADDR7])
    else $error("master and slave causes not reported together");

  a_sbyte_no_restart: assert property (
    (mst_ok && sbyte_cause) |=> abort_cause[`ITA_B_SB_NORS])
    else $error("start byte without restart not flagged");

  a_ten_bit_gate: assert property (
    (st_q.restart_en && !abort_cause[`ITA_B_10B_RD]) |=> !abort_cause[`ITA_B_10B_RD])
    else $error("bit 10 set with restart enabled");

  a_hs_restart_gate: assert property (
    (st_q.restart_en && !abort_cause[`ITA_B_HS_NORS]) |=> !abort_cause[`ITA_B_HS_NORS])
    else $error("bit 8 set with restart enabled");

  a_sbyte_acked: assert property (
    mst_evt.start_byte_acked |=> abort_cause[`ITA_B_SB_ACK])
    else $error("acknowledged start byte not flagged");

  a_hs_acked: assert property (
    (mst_evt.hs_master_code_acked && st_q.hs_mode) |=> abort_cause[`ITA_B_HS_ACK])
    else $error("acknowledged master code not flagged");

  a_hs_ack_gate: assert property (
    (!st_q.hs_mode && !abort_cause[`ITA_B_HS_ACK]) |=> !abort_cause[`ITA_B_HS_ACK])
    else $error("bit 6 set outside high-speed mode");

  a_gc_read_gate: assert property (
    (st_q.general_call_or_start_byte_select_sel && !abort_cause[`ITA_B_GC_READ]) |=> !abort_cause[`ITA_B_GC_READ])
    else $error("bit 5 set with start byte selected");

  a_gc_nack: assert property (
    mst_evt.general_call_unacked |=> abort_cause[`ITA_B_GC_NACK])
    else $error("unacknowledged general call not flagged");

  a_data_nack: assert property (
    (mst_evt.data_byte_unacked && st_q.master_en) |=> abort_cause[`ITA_B_DATA])
    else $error("data byte nack not flagged");

  a_data_master_only: assert property (
    (!st_q.master_en && !abort_cause[`ITA_B_DATA]) |=> !abort_cause[`ITA_B_DATA])
    else $error("bit 3 set with master mode off");

  a_addr10_second: assert property (
    (mst_evt.ten_bit_second_addr_unacked && st_q.ten_bit) |=> abort_cause[`ITA_B_ADDR10_2])
    else $error("second 10-bit address nack not flagged");

  a_addr10_first: assert property (
    (mst_evt.ten_bit_first_addr_unacked && st_q.ten_bit) |=> abort_cause[`ITA_B_ADDR10_1])
    else $error("first 10-bit address nack not flagged");

  a_addr7_gate: assert property (
    (st_q.ten_bit && !abort_cause[`ITA_B_ADDR7]) |=> !abort_cause[`ITA_B_ADDR7])
    else $error("bit 0 set in 10-bit mode");

  a_read_only: assert property (
    !clr |=> (abort_cause & $past(abort_cause)) == $past(abort_cause))
    else $error("cause bit dropped without a clear read");

  a_start_blocked: assert property (
    stop_xfer |-> !master_start)
    else $error("master request accepted while aborted");

  c_master_start: cover property (master_start);
  c_slave_loss: cover property ($rose(abort_cause[`ITA_B_SLV_LOSS]));
  c_sbyte_rearm: cover property (st_q.reassert ##1 abort_cause[`ITA_B_SB_NORS]);
  c_both_roles: cover property (abort_cause[`ITA_B_SLV_FLUSH] && abort_cause[`ITA_B_ADDR7]);
  c_clear: cover property (clr && abort_cause != `ITA_CAUSE_RST);
endmodule : ita_abort_src
`default_nettype wire

// >>> logic/ita_params.svh
// Address map, field positions and reset values of the abort-cause block.
// Assumes a 32-bit APB byte address compared in full.
`ifndef ITA_PARAMS_SVH
`define ITA_PARAMS_SVH
// ==========================================
// Register addresses
`define ITA_ADDR_CTRL 32'h5000_1400
`define ITA_ADDR_TGT 32'h5000_1404
`define ITA_ADDR_DCMD 32'h5000_1410
`define ITA_ADDR_CLR 32'h5000_1454
`define ITA_ADDR_CAUSE 32'h5000_1480
// ==========================================
// Field positions
`define ITA_CTRL_MST_EN 0
`define ITA_CTRL_HS 2
`define ITA_CTRL_RESTART 5
`define ITA_TGT_GC_START 10
`define ITA_TGT_COMMAND_SELECT_A 11
`define ITA_TGT_TENBIT 12
`define ITA_DCMD_CMD 8
`define ITA_DCMD_GC_READ 9
// ==========================================
// Abort cause bit positions
`define ITA_B_ADDR7 0
`define ITA_B_ADDR10_1 1
`define ITA_B_ADDR10_2 2
`define ITA_B_DATA 3
`define ITA_B_GC_NACK 4
`define ITA_B_GC_READ 5
`define ITA_B_HS_ACK 6
`define ITA_B_SB_ACK 7
`define ITA_B_HS_NORS 8
`define ITA_B_SB_NORS 9
`define ITA_B_10B_RD 10
`define ITA_B_MST_DIS 11
`define ITA_B_ARB 12
`define ITA_B_SLV_FLUSH 13
`define ITA_B_SLV_LOSS 14
`define ITA_B_SLV_RD 15
// ==========================================
// Reset values
`define ITA_CAUSE_RST 16'h0000
`define ITA_WORD_RST 32'h0000_0000
// Idle level of the open-drain lines, held by their pull-ups
`define ITA_LINE_IDLE 1'b1
`endif

// >>> logic/ita_pkg.sv
// Types shared by the abort-cause block and its helpers.
// Assumes nothing beyond a SystemVerilog-2012 compiler.
`default_nettype none
package ita_pkg;
  // ==========================================
  // Master engine outcome pulses
  typedef struct packed {
    logic seven_bit_addr_unacked;
    logic ten_bit_first_addr_unacked;
    logic ten_bit_second_addr_unacked;
    logic data_byte_unacked;
    logic general_call_unacked;
    logic start_byte_acked;
    logic hs_master_code_acked;
    logic arbitration_loss;
  } ita_mst_evt_t;
  // ==========================================
  // Slave engine status
  typedef struct packed {
    logic serving_read;
    logic tx_active;
    logic tx_bit;
    logic read_cmd_rx;
    logic tx_fifo_nonempty;
  } ita_slv_t;
  // ==========================================
  // Whole state of the main block
  typedef struct packed {
    logic [15:0] cause;
    logic master_en;
    logic hs_mode;
    logic restart_en;
    logic command_select_a;
    logic general_call_or_start_byte_select_sel;
    logic ten_bit;
    logic reassert;
    logic [31:0] prdata;
    logic err;
  } ita_state_t;
endpackage : ita_pkg
`default_nettype wire

// >>> logic/ita_sync.sv
// Two-flop synchroniser for the bus pins.
// Assumes asynchronous pin levels; output is safe for pclk logic.
`default_nettype none
`include "ita_params.svh"
module ita_sync import ita_pkg::*; #(
  parameter int W = 2
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic [W-1:0] din, // Raw pin levels
  output logic [W-1:0] dout // Synchronised levels
);
  // Refuse an empty synchroniser at elaboration
  if (W < 1) begin : g_w_chk
    $error("ita_sync: W must be positive");
  end
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  // ==========================================
  // Per-bit flop pair; first stage feeds only the second
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        // Idle level, so no false line edge follows reset
        s1_q[i] <= `ITA_LINE_IDLE;
        s2_q[i] <= `ITA_LINE_IDLE;
      end else begin
        s1_q[i] <= din[i];
        s2_q[i] <= s1_q[i];
      end
    end
  end
  assign dout = s2_q;
endmodule : ita_sync
`default_nettype wire

// >>> logic/ita_loss_chk.sv
// Slave-transmitter bus ownership check.
// Assumes synchronised clock and data lines from ita_sync.
`default_nettype none
`include "ita_params.svh"
module ita_loss_chk import ita_pkg::*; (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic scl_s, // Synchronised clock line
  input wire logic sda_s, // Synchronised data line
  input wire logic tx_active, // Slave is driving data
  input wire logic tx_bit, // Bit the slave intends on the line
  output logic loss // One-cycle pulse on mismatch
);
  typedef struct packed {
    logic scl_prev;
    logic loss;
  } ita_chk_t;
  ita_chk_t st_q, st_d;
  // ==========================================
  // Compare at each clock-line rise; open-drain means a zero wins
  always_comb begin
    st_d = st_q;
    st_d.scl_prev = scl_s;
    st_d.loss = tx_active && scl_s && !st_q.scl_prev && (sda_s != tx_bit);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Previous clock starts at idle; zero would fake a rise after reset
      st_q <= '{scl_prev: `ITA_LINE_IDLE, loss: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end
  assign loss = st_q.loss;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_loss_mismatch: assert property (
    (tx_active && $rose(scl_s) && sda_s != tx_bit) |=> loss)
    else $error("slave loss not flagged on mismatch");
endmodule : ita_loss_chk
`default_nettype wire

// >>> verif/ita_bus_model.sv
// Far-side bus party: a remote master that clocks one byte frame.
// Assumes open-drain lines with pull-ups, so both idle high.
`default_nettype none
module ita_bus_model (
  input wire logic go, // Rising edge starts one frame
  input wire logic flip, // Remote pulls data low against the slave
  input wire logic tx_bit, // Bit the slave drives
  output logic scl, // Clock line level
  output logic sda, // Data line level
  output logic busy // Frame in progress
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // Frame generator
  // Clock stands high between frames, as the pull-up leaves it
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    busy = 1'b0;
  end
  // Eight 80 ns periods; each bit moves while the clock is low, the final release with it high
  always @(posedge go) begin
    busy = 1'b1;
    #2; // Step off the pclk edge that raised go
    repeat (8) begin
      #20 scl = 1'b0;
      #20 sda = flip ? 1'b0 : tx_bit; // Wired-AND: remote can only pull low
      #40 scl = 1'b1;
    end
    #40 sda = 1'b1; // Released line returns to the pull-up level
    busy = 1'b0;
  end
endmodule : ita_bus_model
`default_nettype wire

// >>> verif/ita_abort_src_tb.sv
// Self-checking bench for the abort-cause block over APB.
// Assumes the bus model file and the design package are compiled first.
`default_nettype none
`include "ita_params.svh"
module ita_abort_src_tb import ita_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, master_start;
  logic transmit_abort_interrupt, flush_tx, stop_xfer, scl, sda, go, flip, busy, re;
  logic [31:0] paddr, pwdata, prdata, rq;
  logic [15:0] abort_cause;
  logic [2:0] lv;
  ita_mst_evt_t mst_evt;
  ita_slv_t slv;
  int checks, fail_count, starts;
  // Tables: event, control, target, expected cause
  logic [47:0] mtab [0:10] = '{48'h80_01_0000_0001, 48'h80_01_1000_0000,
    48'h40_01_1000_0002, 48'h20_01_1000_0004, 48'h10_01_0000_0008,
    48'h10_00_0000_0000, 48'h08_01_0000_0010, 48'h04_01_0000_0080,
    48'h02_05_0000_0040, 48'h02_01_0000_0000, 48'h01_01_0000_1000};
  // Serving read, control, target, command word, expected cause
  logic [63:0] dtab [0:6] = '{64'h00_00_0000_0000_0800, 64'h00_01_1000_0100_0400,
    64'h00_05_0000_0000_0100, 64'h00_21_0800_0200_0020, 64'h00_21_0000_0000_0000,
    64'h01_21_0000_0100_8000, 64'h01_21_0000_0000_0000};
  assign lv = {transmit_abort_interrupt, flush_tx, stop_xfer};
  // ==========================================
  // Design and far side
  ita_abort_src #(.AW(32)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl),
    .sda_in(sda), .mst_evt(mst_evt), .slv(slv), .master_start(master_start),
    .transmit_abort_interrupt(transmit_abort_interrupt), .flush_tx(flush_tx),
    .stop_xfer(stop_xfer), .abort_cause(abort_cause));
  ita_bus_model i_far (.go(go), .flip(flip), .tx_bit(slv.tx_bit), .scl(scl),
    .sda(sda), .busy(busy));
  // ==========================================
  // Clock and request monitor
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Counted at the edge, before any update lands
  always @(posedge pclk) begin
    if (master_start === 1'b1) starts++;
  end
  // ==========================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 40) begin
      fail_count++;
      tally_and_finish();
    end
  endtask : apb
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic cfg(input logic [7:0] c, input logic [15:0] t);
    wr(`ITA_ADDR_CTRL, {24'h0, c});
    wr(`ITA_ADDR_TGT, {16'h0, t});
  endtask : cfg
  task automatic expect_cause(input logic [15:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, `ITA_ADDR_CAUSE, 32'h0, q, e);
    check(q, {16'h0, x});
    check({13'h0, lv, abort_cause}, {13'h0, {3{|x}}, x});
  endtask : expect_cause
  task automatic clr();
    logic [31:0] q;
    logic e;
    apb(1'b0, `ITA_ADDR_CLR, 32'h0, q, e);
    check(q, 32'h0);
  endtask : clr
  // Engine pulses last exactly one clock
  task automatic pulse(input logic [7:0] ev, input logic rd);
    @(posedge pclk);
    mst_evt <= ita_mst_evt_t'(ev);
    slv.read_cmd_rx <= rd;
    @(posedge pclk);
    mst_evt <= ita_mst_evt_t'(8'h00);
    slv.read_cmd_rx <= 1'b0;
  endtask : pulse
  task automatic frame();
    int n;
    @(posedge pclk);
    go <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((busy === 1'b1 || n < 2) && n < 200);
    go <= 1'b0;
    if (n >= 200) begin
      fail_count++;
      tally_and_finish();
    end
  endtask : frame
  // ==========================================
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, go, flip} = '0;
    paddr = 32'h0;
    pwdata = 32'h0;
    mst_evt = ita_mst_evt_t'(8'h00);
    slv = ita_slv_t'(5'h00);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    expect_cause(16'h0000);
    wr(`ITA_ADDR_CAUSE, 32'h0000_FFFF);
    expect_cause(16'h0000);
    apb(1'b0, 32'h5000_1490, 32'h0, rq, re);
    check({31'h0, re}, 32'h1);
    check(rq, 32'h0);
    $display("test map done");
    for (int i = 0; i < 11; i++) begin
      cfg(mtab[i][39:32], mtab[i][31:16]);
      pulse(mtab[i][47:40], 1'b0);
      expect_cause(mtab[i][15:0]);
      clr();
    end
    $display("test master events done");
    for (int i = 0; i < 7; i++) begin
      slv.serving_read <= dtab[i][56];
      cfg(dtab[i][55:48], dtab[i][47:32]);
      wr(`ITA_ADDR_DCMD, {16'h0, dtab[i][31:16]});
      expect_cause(dtab[i][15:0]);
      clr();
    end
    check(32'(starts), 32'h1);
    slv.serving_read <= 1'b0;
    $display("test commands done");
    // Start byte with restart off, then cleared with the cause still there
    cfg(8'h01, 16'h0C00);
    wr(`ITA_ADDR_DCMD, 32'h0);
    expect_cause(16'h0200);
    apb(1'b0, `ITA_ADDR_CLR, 32'h0, rq, re);
    #1;
    check({31'h0, abort_cause[9]}, 32'h0);
    @(posedge pclk);
    #1;
    check({31'h0, abort_cause[9]}, 32'h1);
    cfg(8'h21, 16'h0C00); // Restart on removes the cause
    clr();
    expect_cause(16'h0000);
    $display("test restart rearm done");
    cfg(8'h01, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      slv.tx_fifo_nonempty <= (i != 1);
      pulse(i == 2 ? 8'h80 : 8'h00, 1'b1);
      expect_cause(i == 0 ? 16'h2000 : i == 1 ? 16'h0000 : 16'h2001);
      clr();
    end
    slv.tx_fifo_nonempty <= 1'b0;
    slv.tx_active <= 1'b1;
    slv.tx_bit <= 1'b1;
    for (int f = 0; f < 2; f++) begin
      flip <= (f == 1);
      frame();
      expect_cause(f == 1 ? 16'h5000 : 16'h0000);
      clr();
    end
    slv.tx_active <= 1'b0;
    $display("test slave causes done");
    tally_and_finish();
  end
endmodule : ita_abort_src_tb
`default_nettype wire
